// ---- bench/usc_chk.sv ----
`include "usc_cfg.svh"
`timescale 1ns/100ps

module usc_chk (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire usc_pkg::usc_word_t S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire usc_pkg::usc_word_t S_AXI_RDATA_OUT,
    input wire usc_pkg::usc_resp_t S_AXI_RRESP_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire usc_pkg::usc_resp_t S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire usc_pkg::usc_level_t RX_LEVEL_IN,
    input wire logic TX_FLUSH_OUT,
    input wire logic RX_FLUSH_OUT,
    input wire logic CTRL_RST_N_OUT,
    input wire logic RTS_N_OUT,
    input wire logic SOUT_OUT,
    input wire logic LOOP_RTS_OUT,
    input wire logic LOOP_RX_OUT
);
    import usc_pkg::*;
    usc_word_t ar_q, ar_d;
    logic mapped;
    // ------------------------------------------------------------
    // Read address capture
    // ------------------------------------------------------------
    always_comb begin
        ar_d = ar_q;
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            ar_d = S_AXI_ARADDR_IN;
        end
    end
    always_ff @(posedge CLK_IN) begin
        ar_q <= ar_d;
    end
    assign mapped = ar_q[31:8] == 24'h500010 && ar_q[7:0] inside
        {8'h84, 8'h88, 8'h8C, 8'h90, 8'h08, 8'h0C, 8'h10};
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    sequence s_rst_hold;
        !CTRL_RST_N_OUT [*2] ##1 CTRL_RST_N_OUT;
    endsequence
    sequence s_no_flush;
        !TX_FLUSH_OUT && !RX_FLUSH_OUT;
    endsequence
    a_level_read: assert property (
        $rose(S_AXI_RVALID_OUT) && ar_q == `USC_ADDR_RX_LEVEL |->
        S_AXI_RDATA_OUT == {16'h0000, $past(RX_LEVEL_IN, 2)})
        else $error("level read");
    a_flush_once: assert property (
        TX_FLUSH_OUT || RX_FLUSH_OUT |=> s_no_flush)
        else $error("flush too long");
    a_flush_on_write: assert property (
        TX_FLUSH_OUT || RX_FLUSH_OUT |-> $rose(S_AXI_BVALID_OUT))
        else $error("stray flush");
    a_soft_release: assert property (
        $fell(CTRL_RST_N_OUT) |-> S_AXI_BVALID_OUT ##1 s_rst_hold)
        else $error("soft reset timing");
    a_loop_rts: assert property (
        LOOP_RTS_OUT |-> RTS_N_OUT)
        else $error("rts in loopback");
    a_loop_break: assert property (
        !LOOP_RX_OUT |-> SOUT_OUT)
        else $error("break on line");
    a_unmapped_rd: assert property (
        $rose(S_AXI_RVALID_OUT) && !mapped |->
        S_AXI_RRESP_OUT == `USC_RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0)
        else $error("unmapped read");
    a_b_hold: assert property (
        S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
        else $error("bresp dropped");
    a_r_hold: assert property (
        S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
        S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("rdata dropped");
endmodule

bind usc_top usc_chk u_chk (.*);

// ---- bench/usc_peer.sv ----
`timescale 1ns/100ps

module usc_peer (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ld_in,
    input wire usc_pkg::usc_level_t lvl_in,
    input wire logic rx_flush_in,
    input wire logic tx_flush_in,
    input wire logic ctrl_rst_n_in,
    output usc_pkg::usc_level_t level_out,
    output logic sout_out,
    output logic sir_n_out,
    output logic [7:0] tx_flushes_out
);
    import usc_pkg::*;
    // Both lines toggle so stale values show
    assign sir_n_out = sout_out;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            level_out <= 16'h0000;
            sout_out <= 1'b1;
            tx_flushes_out <= 8'h00;
        end else begin
            sout_out <= ~sout_out;
            if (tx_flush_in) begin
                tx_flushes_out <= tx_flushes_out + 8'h01;
            end
            if (!ctrl_rst_n_in || rx_flush_in) begin
                level_out <= 16'h0000;
            end else if (ld_in) begin
                level_out <= lvl_in;
            end
        end
    end
endmodule

// ---- bench/usc_top_tb.sv ----
`include "usc_cfg.svh"
`timescale 1ns/100ps

module usc_top_tb;
    import usc_pkg::*;
    logic clk, nrst, awv, wv, bry, arv, rry, ld, txf, rxf, crst;
    logic rts_n, sout, sir_n, lrts, lrx, awr, wrdy, bv, arr, rv;
    logic p_sout, p_sir, ce;
    usc_word_t awa, wd, ara, rdat;
    usc_resp_t br, rr;
    usc_level_t lvl, p_lvl;
    logic [7:0] txn;
    int mismatches, compares, cyc_n;
    usc_level_t thr [4] = '{16'h0001, 16'h0004, 16'h0008, 16'h000E};

    always #12.5 clk = ~clk;

    usc_top #(.SIR_PULSE_CYC(2), .SIR_PERIOD_CYC(8)) dut (
        .CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
        .S_AXI_AWADDR_IN(awa), .S_AXI_AWPROT_IN('0),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
        .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
        .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARPROT_IN('0),
        .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr),
        .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry),
        .RX_LEVEL_IN(p_lvl), .TX_SOUT_IN(p_sout), .TX_SIR_N_IN(p_sir),
        .TX_FLUSH_OUT(txf), .RX_FLUSH_OUT(rxf), .CTRL_RST_N_OUT(crst),
        .RTS_N_OUT(rts_n), .SOUT_OUT(sout), .SIR_OUT_N_OUT(sir_n),
        .LOOP_RTS_OUT(lrts), .LOOP_RX_OUT(lrx)
    );

    usc_peer peer (
        .clk_in(clk), .nrst_in(nrst), .ld_in(ld), .lvl_in(lvl),
        .rx_flush_in(rxf), .tx_flush_in(txf), .ctrl_rst_n_in(crst),
        .level_out(p_lvl), .sout_out(p_sout), .sir_n_out(p_sir),
        .tx_flushes_out(txn)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input usc_word_t s, input usc_word_t e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input usc_word_t a, input usc_word_t d,
                      input usc_resp_t e);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wrdy === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        bry <= 1'b0;
        chk("bresp", br, e);
    endtask

    task automatic rd(input usc_word_t a, output usc_word_t d,
                      input usc_resp_t e);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rry <= 1'b0;
        d = rdat;
        chk("rresp", rr, e);
    endtask

    task automatic rdc(input usc_word_t a, input usc_word_t e);
        usc_word_t d;
        rd(a, d, `USC_RESP_OKAY);
        chk("rdata", d, e);
    endtask

    task automatic setlvl(input usc_level_t v);
        @(posedge clk);
        lvl <= v;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        cyc(4);
    endtask

    task automatic sir_cnt(input usc_word_t e);
        usc_word_t n = 0;
        repeat (16) begin
            @(posedge clk);
            if (sir_n === 1'b0) n++;
        end
        chk("sir_lows", n, e);
    endtask

    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            mismatches++;
            give_verdict;
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        usc_word_t d;
        logic [7:0] n0;
        clk = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        {awv, wv, bry, arv, rry, ld, awa, wd, ara, lvl} = '0;
        cyc(20);
        nrst <= 1'b1;
        cyc(4);
        chk("ctrl_rst", crst, 1);
        rdc(`USC_ADDR_RX_LEVEL, 0);
        rdc(`USC_ADDR_RESET_TRIG, 0);
        rdc(`USC_ADDR_RTS_COPY, 0);
        rdc(`USC_ADDR_BREAK_COPY, 0);
        setlvl(16'h0005);
        rdc(`USC_ADDR_RX_LEVEL, 5);
        wr(`USC_ADDR_RX_LEVEL, 32'h0, `USC_RESP_OKAY);
        rdc(`USC_ADDR_RX_LEVEL, 5);
        wr(`USC_ADDR_RTS_COPY, 32'hFFFF_FFFF, `USC_RESP_OKAY);
        rdc(`USC_ADDR_RTS_COPY, 1);
        rdc(`USC_ADDR_MODEM_CTRL, 32'h2);
        chk("rts_n", rts_n, 0);
        wr(`USC_ADDR_MODEM_CTRL, 32'h0, `USC_RESP_OKAY);
        rdc(`USC_ADDR_RTS_COPY, 0);
        chk("rts_n", rts_n, 1);
        wr(`USC_ADDR_BREAK_COPY, 32'h1, `USC_RESP_OKAY);
        rdc(`USC_ADDR_LINE_CTRL, 32'h40);
        repeat (8) begin
            @(posedge clk);
            chk("sout", sout, 0);
        end
        wr(`USC_ADDR_LINE_CTRL, 32'h0, `USC_RESP_OKAY);
        rdc(`USC_ADDR_BREAK_COPY, 0);
        chk("sout", sout, !p_sout);
        d = p_sout;
        ce <= 1'b0;
        cyc(4);
        chk("sout", sout, d);
        ce <= 1'b1;
        wr(`USC_ADDR_MODEM_CTRL, 32'h40, `USC_RESP_OKAY);
        sir_cnt(8);
        wr(`USC_ADDR_BREAK_COPY, 32'h1, `USC_RESP_OKAY);
        cyc(2);
        sir_cnt(4);
        wr(`USC_ADDR_MODEM_CTRL, 32'h12, `USC_RESP_OKAY);
        cyc(2);
        chk("rts_n", rts_n, 1);
        chk("loop_rts", lrts, 1);
        chk("loop_rx", lrx, 0);
        chk("sout", sout, 1);
        wr(`USC_ADDR_BREAK_COPY, 32'h0, `USC_RESP_OKAY);
        wr(`USC_ADDR_MODEM_CTRL, 32'h22, `USC_RESP_OKAY);
        for (int t = 0; t < 4; t++) begin
            wr(`USC_ADDR_QUEUE_CTRL, {24'h0, t[1:0], 6'h01}, `USC_RESP_OKAY);
            rdc(`USC_ADDR_QUEUE_CTRL, {24'h0, t[1:0], 6'h01});
            setlvl(thr[t] - 16'h0001);
            chk("rts_n", rts_n, 0);
            setlvl(thr[t]);
            chk("rts_n", rts_n, 1);
        end
        wr(`USC_ADDR_MODEM_CTRL, 32'h0, `USC_RESP_OKAY);
        n0 = txn;
        wr(`USC_ADDR_QUEUE_CTRL, 32'h0, `USC_RESP_OKAY);
        wr(`USC_ADDR_RESET_TRIG, 32'h4, `USC_RESP_OKAY);
        cyc(2);
        chk("tx_flush", txn, n0 + 8'h02);
        setlvl(16'h0007);
        wr(`USC_ADDR_RESET_TRIG, 32'h2, `USC_RESP_OKAY);
        cyc(4);
        rdc(`USC_ADDR_RX_LEVEL, 0);
        rdc(`USC_ADDR_RESET_TRIG, 0);
        chk("tx_flush", txn, n0 + 8'h02);
        wr(`USC_ADDR_RTS_COPY, 32'h1, `USC_RESP_OKAY);
        setlvl(16'h0009);
        wr(`USC_ADDR_RESET_TRIG, 32'h1, `USC_RESP_OKAY);
        chk("ctrl_rst", crst, 0);
        cyc(4);
        chk("ctrl_rst", crst, 1);
        rdc(`USC_ADDR_RTS_COPY, 0);
        rdc(`USC_ADDR_RX_LEVEL, 0);
        rd(32'h5000_10F0, d, `USC_RESP_SLVERR);
        chk("rdata", d, 0);
        wr(32'h5000_10F0, 32'hFFFF_FFFF, `USC_RESP_SLVERR);
        give_verdict;
    end
endmodule

// ---- verilog/usc_cfg.svh ----
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define USC_ADDR_RX_LEVEL 32'h5000_1084
`define USC_ADDR_RESET_TRIG 32'h5000_1088
`define USC_ADDR_RTS_COPY 32'h5000_108C
`define USC_ADDR_BREAK_COPY 32'h5000_1090
`define USC_ADDR_QUEUE_CTRL 32'h5000_1008
`define USC_ADDR_LINE_CTRL 32'h5000_100C
`define USC_ADDR_MODEM_CTRL 32'h5000_1010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USC_BIT_TX_FLUSH 2
`define USC_BIT_RX_FLUSH 1
`define USC_BIT_SOFT_RST 0
`define USC_BIT_COPY 0
`define USC_BIT_FIFO_EN 0
`define USC_BIT_Q_RX_FLUSH 1
`define USC_BIT_Q_TX_FLUSH 2
`define USC_TRIG_HI 7
`define USC_TRIG_LO 6
`define USC_BIT_BREAK 6
`define USC_BIT_RTS 1
`define USC_BIT_LOOP 4
`define USC_BIT_AUTO_FLOW 5
`define USC_BIT_SIR 6
`define USC_LEVEL_W 16

// ----------------------------------------------------------------
// Trigger codes
// ----------------------------------------------------------------
`define USC_TRIG_ONE 2'h0
`define USC_TRIG_QUARTER 2'h1
`define USC_TRIG_HALF 2'h2
`define USC_TRIG_NEAR_FULL 2'h3
`define USC_TRIG_SHORT 2

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define USC_RST_BIT 1'b0
`define USC_RST_TRIG 2'h0
`define USC_RST_LEVEL 16'h0000
`define USC_RESP_OKAY 2'h0
`define USC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define USC_CLK_HZ 40000000
`define USC_SIR_PULSE_NS 1600
`define USC_SIR_PERIOD_NS 10000
`define USC_NS_PER_S 1000000000

`endif

// ---- verilog/usc_pkg.sv ----
package usc_pkg;

    typedef logic [31:0] usc_word_t;
    typedef logic [15:0] usc_level_t;
    typedef logic [3:0] usc_strb_t;
    typedef logic [2:0] usc_prot_t;
    typedef logic [1:0] usc_resp_t;

    typedef enum logic {
        USC_BUS_IDLE = 1'b0,
        USC_BUS_RESP = 1'b1
    } usc_bus_st_t;

endpackage

// ---- verilog/usc_rst_if.sv ----
`timescale 1ns/100ps

interface usc_rst_if;
    logic req;
    logic rst_n;

    modport ctl (output req, input rst_n);
    modport sync (input req, output rst_n);
endinterface

// ---- verilog/usc_rst_sync.sv ----
`timescale 1ns/100ps

module usc_rst_sync (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    usc_rst_if.sync rif
);
    import usc_pkg::*;

    logic [1:0] stage_q;
    logic [1:0] stage_d;

    // ----------------------------------------------------------------
    // Release shifter
    // ----------------------------------------------------------------
    always_comb begin
        stage_d = {stage_q[0], 1'b1};
        if (!nrst_in) begin
            stage_d = 2'b00;
        end else if (!ce_in) begin
            stage_d = stage_q;
        end
    end

    always_ff @(posedge clk_in or posedge rif.req) begin
        if (rif.req) begin
            stage_q <= 2'b00;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign rif.rst_n = stage_q[1];

endmodule

// ---- verilog/usc_top.sv ----
// Function
// - Fill level register returns receive queue entry count, zero after reset.
// - Writing one to transmit flush bit empties the transmit queue.
// - Writing one to receive flush bit empties the receive queue.
// - Both flush trigger bits clear themselves after acting.
// - Soft reset bit asserts controller reset at once, releases it on clock.
// - Soft reset covers register and serial side logic, not the bus slave.
// - Request copy and modem control request bit share one storage.
// - Without auto flow or loopback, request output low while request bit is one.
// - Auto flow with queues on forces request high at or above trigger level.
// - Loopback holds request pin high, loops request bit internally.
// - Break copy and line control break bit share one storage.
// - Outside loopback, break holds serial output low until cleared.
// - Outside loopback, infrared mode with break pulses infrared output continuously.
// - Loopback routes break to own receiver, not the output line.
// - Two-bit trigger picks one, quarter, half or two short of full.
`include "usc_cfg.svh"
`timescale 1ns/100ps

module usc_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int SIR_PULSE_CYC =
        (`USC_SIR_PULSE_NS * (`USC_CLK_HZ / 1000000) + 999) / 1000,
    parameter int SIR_PERIOD_CYC =
        (`USC_SIR_PERIOD_NS * (`USC_CLK_HZ / 1000000)) / 1000
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire usc_pkg::usc_word_t S_AXI_AWADDR_IN,
    input wire usc_pkg::usc_prot_t S_AXI_AWPROT_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire usc_pkg::usc_word_t S_AXI_WDATA_IN,
    input wire usc_pkg::usc_strb_t S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output usc_pkg::usc_resp_t S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire usc_pkg::usc_word_t S_AXI_ARADDR_IN,
    input wire usc_pkg::usc_prot_t S_AXI_ARPROT_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output usc_pkg::usc_word_t S_AXI_RDATA_OUT,
    output usc_pkg::usc_resp_t S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire usc_pkg::usc_level_t RX_LEVEL_IN,
    input wire logic TX_SOUT_IN,
    input wire logic TX_SIR_N_IN,
    output logic TX_FLUSH_OUT,
    output logic RX_FLUSH_OUT,
    output logic CTRL_RST_N_OUT,
    output logic RTS_N_OUT,
    output logic SOUT_OUT,
    output logic SIR_OUT_N_OUT,
    output logic LOOP_RTS_OUT,
    output logic LOOP_RX_OUT
);
    import usc_pkg::*;

    localparam int CNT_W = $clog2(SIR_PERIOD_CYC + 1);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input usc_word_t a,
                                      input usc_word_t off);
        addr_hit = (a[31:2] == off[31:2]);
    endfunction

    function automatic usc_level_t trig_level(input logic [1:0] code);
        usc_level_t depth;
        depth = usc_level_t'(FIFO_DEPTH);
        case (code)
            `USC_TRIG_ONE: trig_level = usc_level_t'(1);
            `USC_TRIG_QUARTER: trig_level = depth >> 2;
            `USC_TRIG_HALF: trig_level = depth >> 1;
            `USC_TRIG_NEAR_FULL: trig_level = depth - usc_level_t'(`USC_TRIG_SHORT);
            default: trig_level = depth;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Controller reset synchroniser
    // ----------------------------------------------------------------
    usc_rst_if rif ();

    usc_rst_sync u_rst_sync (
        .clk_in (CLK_IN),
        .nrst_in (NRST_IN),
        .ce_in (CE_IN),
        .rif (rif)
    );

    logic ctl_rst;
    assign ctl_rst = !NRST_IN || !rif.rst_n;
    assign CTRL_RST_N_OUT = rif.rst_n;

    // ----------------------------------------------------------------
    // Bus slave state
    // ----------------------------------------------------------------
    usc_bus_st_t wst_q, wst_d, rst_q, rst_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    usc_word_t waddr_q, waddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
    usc_strb_t wstrb_q, wstrb_d;
    usc_resp_t bresp_q, bresp_d, rresp_q, rresp_d;
    logic wr_en;

    // ----------------------------------------------------------------
    // Shadow and control register state
    // ----------------------------------------------------------------
    logic rts_q, rts_d, loop_q, loop_d, afc_q, afc_d, sir_q, sir_d;
    logic brk_q, brk_d, fen_q, fen_d;
    logic [1:0] trig_q, trig_d;
    logic txf_q, txf_d, rxf_q, rxf_d, ur_q, ur_d;
    usc_level_t lvl_q, lvl_d;
    logic map_ok;

    assign rif.req = ur_q;

    // ----------------------------------------------------------------
    // Bus slave next state
    // ----------------------------------------------------------------
    always_comb begin
        wst_d = wst_q;
        rst_d = rst_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        wr_en = 1'b0;
        map_ok = 1'b0;
        if (S_AXI_AWVALID_IN && awready_q) begin
            aw_have_d = 1'b1;
            waddr_d = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = S_AXI_WDATA_IN;
            wstrb_d = S_AXI_WSTRB_IN;
        end
        if (wst_q == USC_BUS_RESP && S_AXI_BREADY_IN) begin
            wst_d = USC_BUS_IDLE;
        end
        if (aw_have_q && w_have_q && wst_q == USC_BUS_IDLE) begin
            wr_en = 1'b1;
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            wst_d = USC_BUS_RESP;
            map_ok = addr_hit(waddr_q, `USC_ADDR_RX_LEVEL) ||
                     addr_hit(waddr_q, `USC_ADDR_RESET_TRIG) ||
                     addr_hit(waddr_q, `USC_ADDR_RTS_COPY) ||
                     addr_hit(waddr_q, `USC_ADDR_BREAK_COPY) ||
                     addr_hit(waddr_q, `USC_ADDR_QUEUE_CTRL) ||
                     addr_hit(waddr_q, `USC_ADDR_LINE_CTRL) ||
                     addr_hit(waddr_q, `USC_ADDR_MODEM_CTRL);
            bresp_d = map_ok ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
        end
        if (rst_q == USC_BUS_RESP && S_AXI_RREADY_IN) begin
            rst_d = USC_BUS_IDLE;
        end
        if (S_AXI_ARVALID_IN && arready_q) begin
            rst_d = USC_BUS_RESP;
            rresp_d = `USC_RESP_OKAY;
            rdata_d = '0;
            if (addr_hit(S_AXI_ARADDR_IN, `USC_ADDR_RX_LEVEL)) begin
                rdata_d[`USC_LEVEL_W-1:0] = lvl_q;
            end else if (addr_hit(S_AXI_ARADDR_IN, `USC_ADDR_RTS_COPY)) begin
                rdata_d[`USC_BIT_COPY] = rts_q;
            end else if (addr_hit(S_AXI_ARADDR_IN, `USC_ADDR_BREAK_COPY)) begin
                rdata_d[`USC_BIT_COPY] = brk_q;
            end else if (addr_hit(S_AXI_ARADDR_IN, `USC_ADDR_MODEM_CTRL)) begin
                rdata_d[`USC_BIT_RTS] = rts_q;
                rdata_d[`USC_BIT_LOOP] = loop_q;
                rdata_d[`USC_BIT_AUTO_FLOW] = afc_q;
                rdata_d[`USC_BIT_SIR] = sir_q;
            end else if (addr_hit(S_AXI_ARADDR_IN, `USC_ADDR_LINE_CTRL)) begin
                rdata_d[`USC_BIT_BREAK] = brk_q;
            end else if (addr_hit(S_AXI_ARADDR_IN, `USC_ADDR_QUEUE_CTRL)) begin
                rdata_d[`USC_BIT_FIFO_EN] = fen_q;
                rdata_d[`USC_TRIG_HI:`USC_TRIG_LO] = trig_q;
            end else if (!addr_hit(S_AXI_ARADDR_IN,
                                   `USC_ADDR_RESET_TRIG)) begin
                rresp_d = `USC_RESP_SLVERR;
            end
        end
        awready_d = !aw_have_d && (wst_d == USC_BUS_IDLE);
        wready_d = !w_have_d && (wst_d == USC_BUS_IDLE);
        arready_d = (rst_d == USC_BUS_IDLE);
        if (!NRST_IN) begin
            wst_d = USC_BUS_IDLE;
            rst_d = USC_BUS_IDLE;
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            awready_d = 1'b0;
            wready_d = 1'b0;
            arready_d = 1'b0;
            bresp_d = `USC_RESP_OKAY;
            rresp_d = `USC_RESP_OKAY;
            rdata_d = '0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (CE_IN || !NRST_IN) begin
            wst_q <= wst_d;
            rst_q <= rst_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign S_AXI_AWREADY_OUT = awready_q;
    assign S_AXI_WREADY_OUT = wready_q;
    assign S_AXI_ARREADY_OUT = arready_q;
    assign S_AXI_BVALID_OUT = wst_q;
    assign S_AXI_RVALID_OUT = rst_q;
    assign S_AXI_BRESP_OUT = bresp_q;
    assign S_AXI_RRESP_OUT = rresp_q;
    assign S_AXI_RDATA_OUT = rdata_q;

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    always_comb begin
        rts_d = rts_q;
        loop_d = loop_q;
        afc_d = afc_q;
        sir_d = sir_q;
        brk_d = brk_q;
        fen_d = fen_q;
        trig_d = trig_q;
        txf_d = 1'b0;
        rxf_d = 1'b0;
        ur_d = 1'b0;
        lvl_d = RX_LEVEL_IN;
        if (wr_en && wstrb_q[0]) begin
            if (addr_hit(waddr_q, `USC_ADDR_RESET_TRIG)) begin
                txf_d = wdata_q[`USC_BIT_TX_FLUSH];
                rxf_d = wdata_q[`USC_BIT_RX_FLUSH];
                ur_d = wdata_q[`USC_BIT_SOFT_RST];
            end
            if (addr_hit(waddr_q, `USC_ADDR_RTS_COPY)) begin
                rts_d = wdata_q[`USC_BIT_COPY];
            end
            if (addr_hit(waddr_q, `USC_ADDR_BREAK_COPY)) begin
                brk_d = wdata_q[`USC_BIT_COPY];
            end
            if (addr_hit(waddr_q, `USC_ADDR_MODEM_CTRL)) begin
                rts_d = wdata_q[`USC_BIT_RTS];
                loop_d = wdata_q[`USC_BIT_LOOP];
                afc_d = wdata_q[`USC_BIT_AUTO_FLOW];
                sir_d = wdata_q[`USC_BIT_SIR];
            end
            if (addr_hit(waddr_q, `USC_ADDR_LINE_CTRL)) begin
                brk_d = wdata_q[`USC_BIT_BREAK];
            end
            if (addr_hit(waddr_q, `USC_ADDR_QUEUE_CTRL)) begin
                fen_d = wdata_q[`USC_BIT_FIFO_EN];
                trig_d = wdata_q[`USC_TRIG_HI:`USC_TRIG_LO];
                txf_d = wdata_q[`USC_BIT_Q_TX_FLUSH] ||
                        (fen_q && !fen_d);
                rxf_d = wdata_q[`USC_BIT_Q_RX_FLUSH] ||
                        (fen_q && !fen_d);
            end
        end
        if (ctl_rst) begin
            rts_d = `USC_RST_BIT;
            loop_d = `USC_RST_BIT;
            afc_d = `USC_RST_BIT;
            sir_d = `USC_RST_BIT;
            brk_d = `USC_RST_BIT;
            fen_d = `USC_RST_BIT;
            trig_d = `USC_RST_TRIG;
            txf_d = `USC_RST_BIT;
            rxf_d = `USC_RST_BIT;
            ur_d = `USC_RST_BIT;
            lvl_d = `USC_RST_LEVEL;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (CE_IN || ctl_rst) begin
            rts_q <= rts_d;
            loop_q <= loop_d;
            afc_q <= afc_d;
            sir_q <= sir_d;
            brk_q <= brk_d;
            fen_q <= fen_d;
            trig_q <= trig_d;
            txf_q <= txf_d;
            rxf_q <= rxf_d;
            ur_q <= ur_d;
            lvl_q <= lvl_d;
        end
    end

    assign TX_FLUSH_OUT = txf_q;
    assign RX_FLUSH_OUT = rxf_q;

    // ----------------------------------------------------------------
    // Serial side next state
    // ----------------------------------------------------------------
    logic rts_n_q, rts_n_d, sout_q, sout_d, sir_n_q, sir_n_d;
    logic lrts_q, lrts_d, lrx_q, lrx_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q + CNT_W'(1);
        if (!brk_q || cnt_q >= CNT_W'(SIR_PERIOD_CYC - 1)) begin
            cnt_d = '0;
        end
        rts_n_d = !rts_q;
        if (afc_q && fen_q && lvl_q >= trig_level(trig_q)) begin
            rts_n_d = 1'b1;
        end
        lrts_d = 1'b0;
        lrx_d = 1'b1;
        sout_d = brk_q ? 1'b0 : TX_SOUT_IN;
        sir_n_d = 1'b1;
        if (sir_q) begin
            sir_n_d = brk_q ? (cnt_q >= CNT_W'(SIR_PULSE_CYC)) :
                              TX_SIR_N_IN;
        end
        if (loop_q) begin
            rts_n_d = 1'b1;
            lrts_d = rts_q;
            lrx_d = brk_q ? 1'b0 : TX_SOUT_IN;
            sout_d = 1'b1;
            sir_n_d = 1'b1;
        end
        if (ctl_rst) begin
            cnt_d = '0;
            rts_n_d = 1'b1;
            sout_d = 1'b1;
            sir_n_d = 1'b1;
            lrts_d = 1'b0;
            lrx_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (CE_IN || ctl_rst) begin
            cnt_q <= cnt_d;
            rts_n_q <= rts_n_d;
            sout_q <= sout_d;
            sir_n_q <= sir_n_d;
            lrts_q <= lrts_d;
            lrx_q <= lrx_d;
        end
    end

    assign RTS_N_OUT = rts_n_q;
    assign SOUT_OUT = sout_q;
    assign SIR_OUT_N_OUT = sir_n_q;
    assign LOOP_RTS_OUT = lrts_q;
    assign LOOP_RX_OUT = lrx_q;

endmodule
